// File: rtl/srwp_pkg.sv
// srwp_pkg: constants, types and carriers for the status-register write-protect block.
// assumes one 20 MHz clock domain and a command decoder on the same clock.
//
// Operation
// - protect bits 0,0: writes accepted with write-enable latch set; protect pin ignored.
// - protect bits 0,1 with protect pin low: every status write refused.
// - protect bits 0,1 with protect pin high: writes accepted with write-enable latch.
// - protect bits 1,0: all status writes refused until next reset of any kind.
// - protect bits 1,1, lock clear: writes refused until next reset.
// - protect bits 1,1, lock set: writes refused forever, no reset lifts it.
// - reset with stored protect bits 0,0 or 0,1 loads same values.
// - reset with stored protect bits 1,0 loads 0,0.
// - reset with stored bits 1,1 and lock clear loads 0,1.
// - reset with stored bits 1,1 and lock set keeps 1,1.
// - third register bit 7 picks shared pin role: 0 hold, 1 reset; reloads stored value on reset.
// - hold/reset role applies only while quad enable is clear.
// - quad enable set: protect and hold/reset pins become data lines, functions off.
// - high protect bit is bit 0 of second register, combined with low bit and pin.
package srwp_pkg;
   // register selectors of the write/read command port
   localparam logic [1:0] SRWP_SEL_ONE = 2'h0;
   localparam logic [1:0] SRWP_SEL_TWO = 2'h1;
   localparam logic [1:0] SRWP_SEL_THREE = 2'h2;
   localparam logic [1:0] SRWP_SEL_FOUR = 2'h3;
   // field positions
   localparam int SRWP_PROTECT_LOW_BIT = 7;      // register one
   localparam int SRWP_PROTECT_HIGH_BIT = 0;     // register two
   localparam int SRWP_QUAD_ENABLE_BIT = 1;      // register two
   localparam int SRWP_PIN_ROLE_BIT = 7;         // register three
   localparam int SRWP_PERMANENT_LOCK_BIT = 0;   // register four
   // reset values of the volatile images before the reload
   localparam logic [7:0] SRWP_RESET_BYTE = 8'h00;

   typedef enum logic [3:0] {
      SRWP_PROT_SOFTWARE = 4'h1,
      SRWP_PROT_HARDWARE = 4'h2,
      SRWP_PROT_LOCKDOWN = 4'h4,
      SRWP_PROT_PERMANENT = 4'h8
   } srwp_prot_type;

   typedef enum logic [1:0] {
      SRWP_ST_LOAD = 2'h1,
      SRWP_ST_RUN = 2'h2
   } srwp_state_type;

   typedef struct packed {
      logic [7:0] one;
      logic [7:0] two;
      logic [7:0] three;
      logic [7:0] four;
   } srwp_regs_type;

   typedef struct packed {
      logic valid;
      logic [1:0] sel;
      logic [7:0] data;
   } srwp_write_type;

   typedef struct packed {
      logic done;
      logic refused;
   } srwp_answer_type;

   typedef struct packed {
      logic quad_mode;
      logic hold_active;
      logic pin_reset;
   } srwp_pin_type;
endpackage : srwp_pkg

// File: rtl/srwp_protect.sv
// srwp_protect: volatile status images, protection decision and reset reload.
// assumes the non-volatile image arrives stable on nv_regs_i and is persisted by the
// storage side on each nv_prog_o pulse; pins are asynchronous to sys_clk_i.
`timescale 1ns/10ps
module srwp_protect
   import srwp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire srwp_write_type wr_i,
   input wire logic write_enable_latch_i,
   input wire logic sw_reset_i,
   input wire logic [1:0] rd_sel_i,
   input wire srwp_regs_type nv_regs_i,
   input wire logic protect_pin_n_i,
   input wire logic hold_reset_pin_n_i,
   output srwp_answer_type answer_o,
   output logic [7:0] rd_data_o,
   output srwp_prot_type prot_o,
   output srwp_pin_type pin_o,
   output logic nv_prog_o,
   output srwp_regs_type nv_data_o
);
   // whole module state in one struct, registered as a unit
   typedef struct packed {
      srwp_state_type state;
      srwp_regs_type regs;
      logic [1:0] wp_sync;
      logic [1:0] hr_sync;
      srwp_answer_type answer;
      logic [7:0] rd_data;
      srwp_prot_type prot;
      srwp_pin_type pin;
      logic nv_prog;
      srwp_regs_type nv_data;
   } srwp_core_type;

   srwp_core_type r;
   srwp_core_type next_r;

   // decoded views of the current volatile image
   logic prot_high;
   logic prot_low;
   logic perm_lock;
   logic quad_on;
   logic wp_level;
   logic hr_level;
   logic pin_reset_now;
   logic write_ok;
   srwp_prot_type prot_now;

   // candidate images for a write and for a reload
   srwp_regs_type wr_image;
   srwp_regs_type load_image;

   always_comb begin
      prot_high = r.regs.two[SRWP_PROTECT_HIGH_BIT];
      prot_low = r.regs.one[SRWP_PROTECT_LOW_BIT];
      perm_lock = r.regs.four[SRWP_PERMANENT_LOCK_BIT];
      quad_on = r.regs.two[SRWP_QUAD_ENABLE_BIT];
      // only the second synchroniser stage is read here
      // with quad on both pins are data lines: protect reads high, hold/reset idle
      wp_level = quad_on | r.wp_sync[1];
      hr_level = quad_on | r.hr_sync[1];
      pin_reset_now = ~hr_level & r.regs.three[SRWP_PIN_ROLE_BIT];

      // protection type from the volatile bits
      case ({prot_high, prot_low})
         2'b00: begin
            prot_now = SRWP_PROT_SOFTWARE;
         end
         2'b01: begin
            prot_now = SRWP_PROT_HARDWARE;
         end
         2'b10: begin
            prot_now = SRWP_PROT_LOCKDOWN;
         end
         default: begin
            if (perm_lock) begin
               prot_now = SRWP_PROT_PERMANENT;
            end else begin
               prot_now = SRWP_PROT_LOCKDOWN;
            end
         end
      endcase

      // a write passes only with the latch set and an open protection state
      // latch is looked at in the request cycle only; the host holds it with valid
      write_ok = 1'b0;
      if (write_enable_latch_i) begin
         if (prot_now == SRWP_PROT_SOFTWARE) begin
            write_ok = 1'b1;
         end else if (prot_now == SRWP_PROT_HARDWARE) begin
            write_ok = wp_level;
         end
      end

      // whole byte replaced; reserved bits are the host's to keep
      wr_image = r.regs;
      case (wr_i.sel)
         SRWP_SEL_ONE: begin
            wr_image.one = wr_i.data;
         end
         SRWP_SEL_TWO: begin
            wr_image.two = wr_i.data;
         end
         SRWP_SEL_THREE: begin
            wr_image.three = wr_i.data;
         end
         default: begin
            wr_image.four = wr_i.data;
         end
      endcase

      // reload: stored bytes, with the protect pair remapped
      load_image = nv_regs_i;
      case ({nv_regs_i.two[SRWP_PROTECT_HIGH_BIT], nv_regs_i.one[SRWP_PROTECT_LOW_BIT]})
         2'b00, 2'b01: begin
            load_image = nv_regs_i;
         end
         2'b10: begin
            load_image.two[SRWP_PROTECT_HIGH_BIT] = 1'b0;
            load_image.one[SRWP_PROTECT_LOW_BIT] = 1'b0;
         end
         default: begin
            if (!nv_regs_i.four[SRWP_PERMANENT_LOCK_BIT]) begin
               load_image.two[SRWP_PROTECT_HIGH_BIT] = 1'b0;
               load_image.one[SRWP_PROTECT_LOW_BIT] = 1'b1;
            end else begin
               // lock set: pair stays 1,1, registers unwritable for good
               load_image = nv_regs_i;
            end
         end
      endcase
   end

   always_comb begin
      next_r = r;
      next_r.wp_sync = {r.wp_sync[0], protect_pin_n_i};
      next_r.hr_sync = {r.hr_sync[0], hold_reset_pin_n_i};
      next_r.answer = '0;
      next_r.nv_prog = 1'b0;
      case (r.state)
         SRWP_ST_LOAD: begin
            // requests arriving during reload are refused, nothing stored
            // held here while the pin keeps reset, so the reload repeats
            next_r.regs = load_image;
            next_r.answer.refused = wr_i.valid;
            if (!pin_reset_now) begin
               next_r.state = SRWP_ST_RUN;
            end
         end
         SRWP_ST_RUN: begin
            if (sw_reset_i || pin_reset_now) begin
               // any reset lifts lockdown but never the permanent lock
               next_r.state = SRWP_ST_LOAD;
               next_r.answer.refused = wr_i.valid;
            end else if (wr_i.valid) begin
               if (write_ok) begin
                  next_r.regs = wr_image;
                  next_r.nv_prog = 1'b1;
                  next_r.nv_data = wr_image;
                  next_r.answer.done = 1'b1;
               end else begin
                  // refused write leaves every bit, protect pair included
                  next_r.answer.refused = 1'b1;
               end
            end
         end
         default: begin
            next_r.state = SRWP_ST_LOAD;
         end
      endcase
      // read path shows the image after this cycle's update
      case (rd_sel_i)
         SRWP_SEL_ONE: begin
            next_r.rd_data = next_r.regs.one;
         end
         SRWP_SEL_TWO: begin
            next_r.rd_data = next_r.regs.two;
         end
         SRWP_SEL_THREE: begin
            next_r.rd_data = next_r.regs.three;
         end
         default: begin
            next_r.rd_data = next_r.regs.four;
         end
      endcase
      next_r.prot = prot_now;

      // pin roles: hold with role 0, reset with role 1, both off in quad mode
      next_r.pin.quad_mode = quad_on;
      next_r.pin.hold_active = ~hr_level & ~r.regs.three[SRWP_PIN_ROLE_BIT];
      next_r.pin.pin_reset = pin_reset_now;
   end

   // async clear stands for power-up; the reload follows on the first edge
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         // power-on: images cleared, then reloaded from storage after release
         r.state <= SRWP_ST_LOAD;
         r.regs <= {4{SRWP_RESET_BYTE}};
         r.wp_sync <= 2'h3;
         r.hr_sync <= 2'h3;
         r.answer <= '0;
         r.rd_data <= SRWP_RESET_BYTE;
         r.prot <= SRWP_PROT_SOFTWARE;
         r.pin <= '0;
         r.nv_prog <= 1'b0;
         r.nv_data <= {4{SRWP_RESET_BYTE}};
      end else begin
         r <= next_r;
      end
   end

   // every output is a register field
   assign answer_o = r.answer;
   assign rd_data_o = r.rd_data;
   assign prot_o = r.prot;
   assign pin_o = r.pin;
   assign nv_prog_o = r.nv_prog;
   assign nv_data_o = r.nv_data;
endmodule : srwp_protect

// File: bench/srwp_checker.sv
// srwp_checker: port-level checks of srwp_protect.
// assumes one clock, async active-low reset; bound at the foot of this file.
`timescale 1ns/10ps
module srwp_checker
   import srwp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire srwp_write_type wr_i,
   input wire logic write_enable_latch_i,
   input wire logic sw_reset_i,
   input wire logic [1:0] rd_sel_i,
   input wire logic protect_pin_n_i,
   input wire srwp_answer_type answer_o,
   input wire logic [7:0] rd_data_o,
   input wire srwp_prot_type prot_o,
   input wire srwp_pin_type pin_o,
   input wire logic nv_prog_o
);
   logic [1:0] age;
   // prot_o lags a reload, so decisions are judged only once settled
   always_ff @(posedge sys_clk_i or negedge resetn_i)
      if (!resetn_i) age <= 2'h0;
      else age <= (sw_reset_i || pin_o.pin_reset) ? 2'h0 : age + {1'b0, age != 2'h3};
   wire ok = age == 2'h3 && !sw_reset_i && !answer_o.done;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_take; wr_i.valid && ok ##1 !wr_i.valid; endsequence
   sequence s_ans; (answer_o.done ^ answer_o.refused) ##1 !(answer_o.done || answer_o.refused);
   endsequence
   property p_sw; wr_i.valid && write_enable_latch_i && ok && prot_o == SRWP_PROT_SOFTWARE
      |=> answer_o.done; endproperty
   a_sw: assert property (p_sw) else $error("soft write refused");
   property p_hwlo; wr_i.valid && ok && prot_o == SRWP_PROT_HARDWARE && !pin_o.quad_mode
      && !protect_pin_n_i && !$past(protect_pin_n_i, 2) |=> answer_o.refused; endproperty
   a_hwlo: assert property (p_hwlo) else $error("hw write passed");
   property p_hwhi; wr_i.valid && write_enable_latch_i && ok && prot_o == SRWP_PROT_HARDWARE
      && protect_pin_n_i && $past(protect_pin_n_i, 2) |=> answer_o.done; endproperty
   a_hwhi: assert property (p_hwhi) else $error("hw write refused");
   property p_lock; wr_i.valid && ok && (prot_o == SRWP_PROT_LOCKDOWN
      || prot_o == SRWP_PROT_PERMANENT) |=> answer_o.refused && !nv_prog_o; endproperty
   a_lock: assert property (p_lock) else $error("locked write passed");
   property p_wel; wr_i.valid && !write_enable_latch_i |=> answer_o.refused; endproperty
   a_wel: assert property (p_wel) else $error("latch low write passed");
   property p_keep; answer_o.refused && $stable(rd_sel_i) |-> $stable(rd_data_o) && !nv_prog_o;
   endproperty
   a_keep: assert property (p_keep) else $error("refused write changed state");
   property p_ans; s_take |-> s_ans; endproperty
   a_ans: assert property (p_ans) else $error("answer not one pulse");
   property p_quad; pin_o.quad_mode |-> !pin_o.hold_active && !pin_o.pin_reset; endproperty
   a_quad: assert property (p_quad) else $error("pin function in quad");
endmodule : srwp_checker
bind srwp_protect srwp_checker u_srwp_checker (.*);

// File: bench/srwp_host.sv
// srwp_host: host model issuing status writes and software resets.
// assumes the write port of srwp_protect on the same clock.
`timescale 1ns/10ps
module srwp_host
   import srwp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire srwp_answer_type answer_i,
   output srwp_write_type wr_o,
   output logic latch_o,
   output logic sw_reset_o
);
   initial begin
      wr_o = '0;
      latch_o = 1'b0;
      sw_reset_o = 1'b0;
   end
   task automatic write(input logic [1:0] s, input logic [7:0] d, input logic l,
      output srwp_answer_type a);
      @(posedge sys_clk_i);
      wr_o <= '{valid: 1'b1, sel: s, data: d};
      latch_o <= l;
      @(posedge sys_clk_i);
      wr_o <= '{valid: 1'b0, sel: ~s, data: ~d};
      latch_o <= 1'b0;
      // answer stands for this one cycle; read it once settled
      @(negedge sys_clk_i);
      a = answer_i;
   endtask : write
   task automatic soft_reset();
      @(posedge sys_clk_i);
      sw_reset_o <= 1'b1;
      @(posedge sys_clk_i);
      sw_reset_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask : soft_reset
endmodule : srwp_host

// File: bench/tb_status_reg_write_protect.sv
// tb_status_reg_write_protect: self-checking bench of srwp_protect.
// assumes srwp_host as the command side and the bound checker.
`timescale 1ns/10ps
module tb_status_reg_write_protect;
   import srwp_pkg::*;
   logic clk, rstn, latch, swr, pp, hp, nvp;
   srwp_regs_type nv, nvd;
   srwp_write_type wr;
   srwp_answer_type ao, ans;
   srwp_prot_type prot;
   srwp_pin_type pin;
   logic [7:0] rd;
   logic [9:0] r;
   int errors = 0;
   int n_tests = 0;
   // nv high, nv low, lock, protect pin, latch | done, prot
   logic [9:0] rows [7] = '{10'h031, 10'h122, 10'h172, 10'h231, 10'h322, 10'h3e8, 10'h041};
   srwp_protect u_srwp_protect (.sys_clk_i(clk), .resetn_i(rstn), .wr_i(wr),
      .write_enable_latch_i(latch), .sw_reset_i(swr), .rd_sel_i(SRWP_SEL_THREE),
      .nv_regs_i(nv), .protect_pin_n_i(pp), .hold_reset_pin_n_i(hp), .answer_o(ao),
      .rd_data_o(rd), .prot_o(prot), .pin_o(pin), .nv_prog_o(nvp), .nv_data_o(nvd));
   srwp_host u_srwp_host (.sys_clk_i(clk), .answer_i(ao), .wr_o(wr), .latch_o(latch),
      .sw_reset_o(swr));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chkp(input logic [3:0] e);
      chk("prot", {4'h0, e}, {4'h0, prot});
   endtask : chkp
   task automatic results();
      if (errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #150000;
      errors++;
      results();
   end
   initial begin
      rstn = 1'b0;
      nv = '0;
      pp = 1'b1;
      hp = 1'b1;
      repeat (3) @(posedge clk);
      chkp(4'h1);
      chk("rst", 8'h00, rd);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         r = rows[i];
         nv <= {r[8], 7'h00, 7'h00, r[9], 8'h00, 7'h00, r[7]};
         pp <= r[6];
         u_srwp_host.soft_reset();
         chkp(r[3:0]);
         u_srwp_host.write(SRWP_SEL_THREE, 8'h5a, r[5], ans);
         chk("done", {7'h00, r[4]}, {7'h00, ans.done});
         chk("prog", {7'h00, r[4]}, {7'h00, nvp});
         chk("rd", r[4] ? 8'h5a : 8'h00, rd);
      end
      u_srwp_host.write(SRWP_SEL_TWO, 8'h01, 1'b1, ans);
      u_srwp_host.write(SRWP_SEL_THREE, 8'h5a, 1'b1, ans);
      chk("lockdn", 8'h01, {7'h00, ans.refused});
      chkp(SRWP_PROT_LOCKDOWN);
      u_srwp_host.soft_reset();
      chkp(SRWP_PROT_SOFTWARE);
      u_srwp_host.write(SRWP_SEL_ONE, 8'h80, 1'b1, ans);
      u_srwp_host.write(SRWP_SEL_TWO, 8'h01, 1'b1, ans);
      chk("hwup", 8'h01, {7'h00, ans.done});
      u_srwp_host.write(SRWP_SEL_THREE, 8'h5a, 1'b1, ans);
      chk("lock11", 8'h01, {7'h00, ans.refused});
      chkp(SRWP_PROT_LOCKDOWN);
      u_srwp_host.soft_reset();
      chkp(SRWP_PROT_SOFTWARE);
      u_srwp_host.write(SRWP_SEL_THREE, 8'h80, 1'b1, ans);
      @(posedge clk);
      hp <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("pinrole", 8'h01, {7'h00, pin.pin_reset});
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("pinrst", 8'h00, rd);
      chk("hold", 8'h01, {7'h00, pin.hold_active});
      u_srwp_host.write(SRWP_SEL_TWO, 8'h02, 1'b1, ans);
      chk("nvdat", 8'h02, nvd.two);
      @(negedge clk);
      chk("quad", 8'h02, {6'h00, pin.quad_mode, pin.hold_active});
      u_srwp_host.write(SRWP_SEL_ONE, 8'h80, 1'b1, ans);
      @(posedge clk);
      pp <= 1'b0;
      repeat (3) @(posedge clk);
      u_srwp_host.write(SRWP_SEL_THREE, 8'h33, 1'b1, ans);
      chk("quadwp", 8'h01, {7'h00, ans.done});
      chk("quadrd", 8'h33, rd);
      repeat (2) @(negedge clk);
      results();
   end
endmodule : tb_status_reg_write_protect
